// ### csre_defs.svh
`ifndef CSRE_DEFS_SVH
`define CSRE_DEFS_SVH
// ==========================================================
// request command codes
`define CSRE_CMD_SET_CFGA   8'h81
`define CSRE_CMD_GET_CFGA   8'h82
`define CSRE_CMD_SET_CLREF  8'h83
`define CSRE_CMD_GET_CLREF  8'h84
`define CSRE_CMD_GET_STS0   8'h85
`define CSRE_CMD_GET_STS1   8'h86
// ==========================================================
// reply header layout
`define CSRE_HDR_ACK_BIT    6
`define CSRE_HDR_UNSOL      8'h80
`define CSRE_HDR_CODE_MASK  8'h3f
// ==========================================================
// drive_config_a field positions
`define CSRE_CFGA_RSVD      7
`define CSRE_CFGA_PU_KEEP   6
`define CSRE_CFGA_SLEEP     5
`define CSRE_CFGA_NEUSIM    4
`define CSRE_CFGA_UNDERVOLTAGE_LOCKOUT_DIS  3
`define CSRE_CFGA_OC_DIS    2
`define CSRE_CFGA_MASK      8'h7f
// ==========================================================
// reset values, status 1 config-lost bit and fault mask
`define CSRE_CFGA_RST       8'h00
`define CSRE_CLREF_RST      8'h40
`define CSRE_STS0_RST       8'h01
`define CSRE_STS1_CFG_LOST  4
`define CSRE_STS1_MASK      8'h2c
// ==========================================================
// current limit reference transfer, in microvolts
`define CSRE_CLREF_OFS_UV   991000
`define CSRE_CLREF_STEP_UV  13770
`endif

// ### csre_pkg.sv
`default_nettype none
package csre_pkg;
    typedef enum logic [1:0] {
        CSRE_IDLE,
        CSRE_HDR,
        CSRE_DATA
    } csre_state_e;
    typedef enum logic [1:0] {
        CSRE_SRC_CFGA,
        CSRE_SRC_CLREF,
        CSRE_SRC_STS0,
        CSRE_SRC_STS1
    } csre_src_e;
endpackage : csre_pkg
`default_nettype wire

// ### csre_fault_watch.sv
`timescale 1ns/1ps
`default_nettype none
`include "csre_defs.svh"
// ==========================================================
// change detector for one status byte: a pending flag is raised on
// any newly set bit and held until the encoder takes it
module csre_fault_watch #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] flags_i,
    input  wire logic         take_i,
    output logic              pend_o
);
    logic [W-1:0] last_r;
    logic         pend_r;
    wire          rise = |(flags_i & ~last_r);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            // flags already up during reset count as seen: no false fault after release
            last_r <= flags_i;
            pend_r <= 1'b0;
        end else begin
            last_r <= flags_i;
            // a new fault in the take cycle keeps the flag up
            pend_r <= rise | (pend_r & ~take_i);
        end
    end
    assign pend_o = pend_r;
endmodule : csre_fault_watch
`default_nettype wire

// ### csre_encoder.sv
// Operation
// - write of drive config answers 01h refused, 41h accepted
// - config bit 7 reads zero; bit 6 keeps pull-up, default zero, ignored asleep
// - config bit 5 picks sleep (1) or standby (0) when drive enable low
// - config bit 4 enables the neutral simulator, start-up zero
// - config bit 3 set disables undervoltage lockout, default zero
// - config bit 2 set disables external overcurrent detection, default zero
// - config bits 1:0 pick overcurrent threshold 0.25 to 1.0 volt
// - read of drive config answers 02h or 42h, then config byte
// - write of current reference answers 03h or 43h, then code
// - reference code maps to 0.991 volt plus 13.77 millivolt per step
// - read of current reference answers 04h or 44h, then code
// - status 0 request answers 05h or 45h, then status byte
// - status 0 fault sent unsolicited with header 85h
// - status 0 bits 0..4: warning, overtemp, undervolt, driver overvolt, overvolt
// - status 0 bits 5..7: buck overcurrent, buck warning, buck brown-out
// - status 1 request answers 06h or 46h, then status byte
// - status 1 fault sent unsolicited with header 86h
// - status 1 bits 2,3,5 are faults; bits 0,1,6,7 reserved zero
// - status 1 bit 4 flags config lost, set after start-up
`timescale 1ns/1ps
`default_nettype none
`include "csre_defs.svh"
module csre_encoder (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       req_valid_i,
    input  wire logic [7:0] req_cmd_i,
    input  wire logic [7:0] req_data_i,
    input  wire logic       in_standby_i,
    input  wire logic       drive_en_i,
    input  wire logic [7:0] sts0_i,
    input  wire logic [7:0] sts1_i,
    input  wire logic       tx_ready_i,
    output logic            req_ready_o,
    output logic            tx_valid_o,
    output logic [7:0]      tx_byte_o,
    output logic            tx_last_o,
    output logic [7:0]      drive_config_a_o,
    output logic [7:0]      current_limit_reference_o,
    output logic            pullup_disconnect_o,
    output logic            sleep_entry_o,
    output logic            standby_entry_o,
    output logic            neutral_sim_en_o,
    output logic            undervoltage_lockout_en_o,
    output logic            ext_oc_detect_en_o,
    output logic [1:0]      ext_oc_thresh_o,
    output logic [31:0]     clref_uv_o
);
    // ==========================================================
    // request decode
    function automatic logic cmd_known(input logic [7:0] c);
        cmd_known = (c >= `CSRE_CMD_SET_CFGA) && (c <= `CSRE_CMD_GET_STS1);
    endfunction : cmd_known

    csre_pkg::csre_state_e state_r;
    csre_pkg::csre_src_e   src_r;
    logic [7:0] cfga_r;
    logic [7:0] clref_r;
    logic       cfg_lost_r;
    logic       ack_r;
    logic       tx_valid_r;
    logic [7:0] tx_byte_r;
    logic       tx_last_r;
    logic       req_ready_r;
    logic       pend0;
    logic       pend1;
    logic       take0;
    logic       take1;

    wire        idle       = (state_r == csre_pkg::CSRE_IDLE);
    wire        req_take   = idle & req_valid_i;
    wire        known      = cmd_known(req_cmd_i);
    // sleep select may change only in standby; a write trying it otherwise is refused
    wire        sleep_chg  = (req_data_i[`CSRE_CFGA_SLEEP] != cfga_r[`CSRE_CFGA_SLEEP]);
    wire        set_cfga   = req_cmd_i == `CSRE_CMD_SET_CFGA;
    wire        cfga_ok    = ~sleep_chg | in_standby_i;
    wire        req_ack    = known & req_cmd_i[7] & (~set_cfga | cfga_ok);
    wire        wr_cfga    = req_take & req_ack & set_cfga;
    wire        wr_clref   = req_take & req_ack & (req_cmd_i == `CSRE_CMD_SET_CLREF);
    // host requests win over unsolicited frames; faults stay pending meanwhile
    wire        unsol_go   = idle & ~req_valid_i & (pend0 | pend1);
    wire [7:0]  hdr_code   = req_cmd_i & `CSRE_HDR_CODE_MASK;
    wire [7:0]  hdr_nxt    = {1'b0, req_ack, hdr_code[5:0]};
    wire [7:0]  sts1_full  = (sts1_i & `CSRE_STS1_MASK)
                           | ({7'h00, cfg_lost_r} << `CSRE_STS1_CFG_LOST);
    csre_pkg::csre_src_e src_nxt;
    assign src_nxt = (req_cmd_i <= `CSRE_CMD_GET_CFGA)  ? csre_pkg::CSRE_SRC_CFGA  :
                     (req_cmd_i <= `CSRE_CMD_GET_CLREF) ? csre_pkg::CSRE_SRC_CLREF :
                     (req_cmd_i == `CSRE_CMD_GET_STS0)  ? csre_pkg::CSRE_SRC_STS0  :
                                                          csre_pkg::CSRE_SRC_STS1;
    wire [7:0]  data_sel   = (src_r == csre_pkg::CSRE_SRC_CFGA)  ? cfga_r  :
                             (src_r == csre_pkg::CSRE_SRC_CLREF) ? clref_r :
                             (src_r == csre_pkg::CSRE_SRC_STS0)  ? sts0_i  : sts1_full;
    wire        tx_fire    = tx_valid_r & tx_ready_i;

    assign take0 = unsol_go & pend0;
    assign take1 = unsol_go & ~pend0;

    // ==========================================================
    // unsolicited fault watchers
    csre_fault_watch #(.W(8)) u_watch0 (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .flags_i (sts0_i),
        .take_i  (take0),
        .pend_o  (pend0)
    );
    csre_fault_watch #(.W(8)) u_watch1 (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .flags_i (sts1_i & `CSRE_STS1_MASK),
        .take_i  (take1),
        .pend_o  (pend1)
    );

    // ==========================================================
    // configuration registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfga_r     <= `CSRE_CFGA_RST;
            clref_r    <= `CSRE_CLREF_RST;
            cfg_lost_r <= 1'b1;
        end else begin
            if (wr_cfga) begin
                cfga_r     <= req_data_i & `CSRE_CFGA_MASK;
                cfg_lost_r <= 1'b0;
            end
            if (wr_clref) begin
                clref_r    <= req_data_i;
                cfg_lost_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // reply sequencer
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r     <= csre_pkg::CSRE_IDLE;
            src_r       <= csre_pkg::CSRE_SRC_CFGA;
            ack_r       <= 1'b0;
            tx_valid_r  <= 1'b0;
            tx_byte_r   <= 8'h00;
            tx_last_r   <= 1'b0;
            req_ready_r <= 1'b0;
        end else begin
            req_ready_r <= 1'b0;
            case (state_r)
                csre_pkg::CSRE_IDLE: begin
                    req_ready_r <= 1'b1;
                    if (req_valid_i) begin
                        req_ready_r <= 1'b0;
                        src_r       <= src_nxt;
                        ack_r       <= req_ack;
                        tx_valid_r  <= 1'b1;
                        tx_byte_r   <= hdr_nxt;
                        tx_last_r   <= ~req_ack;
                        state_r     <= csre_pkg::CSRE_HDR;
                    end else if (unsol_go) begin
                        req_ready_r <= 1'b0;
                        src_r       <= pend0 ? csre_pkg::CSRE_SRC_STS0
                                             : csre_pkg::CSRE_SRC_STS1;
                        ack_r       <= 1'b1;
                        tx_valid_r  <= 1'b1;
                        tx_byte_r   <= `CSRE_HDR_UNSOL | (pend0 ? `CSRE_CMD_GET_STS0
                                                            : `CSRE_CMD_GET_STS1);
                        tx_last_r   <= 1'b0;
                        state_r     <= csre_pkg::CSRE_HDR;
                    end
                end
                csre_pkg::CSRE_HDR: begin
                    if (tx_fire) begin
                        if (ack_r) begin
                            // value sampled after any write took effect
                            tx_byte_r <= data_sel;
                            tx_last_r <= 1'b1;
                            state_r   <= csre_pkg::CSRE_DATA;
                        end else begin
                            tx_valid_r <= 1'b0;
                            tx_last_r  <= 1'b0;
                            state_r    <= csre_pkg::CSRE_IDLE;
                        end
                    end
                end
                csre_pkg::CSRE_DATA: begin
                    if (tx_fire) begin
                        tx_valid_r <= 1'b0;
                        tx_last_r  <= 1'b0;
                        state_r    <= csre_pkg::CSRE_IDLE;
                    end
                end
                default: state_r <= csre_pkg::CSRE_IDLE;
            endcase
        end
    end

    // ==========================================================
    // decoded controls, registered
    logic [7:0]  ctl_r;
    logic [31:0] uv_r;
    wire         asleep = cfga_r[`CSRE_CFGA_SLEEP];
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctl_r <= 8'h00;
            uv_r  <= 32'(`CSRE_CLREF_OFS_UV);
        end else begin
            // pull-up keep bit has no say once sleep is selected
            ctl_r[0] <= ~drive_en_i & (asleep | ~cfga_r[`CSRE_CFGA_PU_KEEP]);
            ctl_r[1] <= ~drive_en_i & asleep;
            ctl_r[2] <= ~drive_en_i & ~asleep;
            ctl_r[3] <= cfga_r[`CSRE_CFGA_NEUSIM];
            ctl_r[4] <= ~cfga_r[`CSRE_CFGA_UNDERVOLTAGE_LOCKOUT_DIS];
            ctl_r[5] <= ~cfga_r[`CSRE_CFGA_OC_DIS];
            ctl_r[7:6] <= cfga_r[1:0];
            uv_r  <= 32'(`CSRE_CLREF_OFS_UV)
                   + 32'(clref_r) * 32'(`CSRE_CLREF_STEP_UV);
        end
    end

    assign req_ready_o               = req_ready_r;
    assign tx_valid_o                = tx_valid_r;
    assign tx_byte_o                 = tx_byte_r;
    assign tx_last_o                 = tx_last_r;
    assign drive_config_a_o          = cfga_r;
    assign current_limit_reference_o = clref_r;
    assign pullup_disconnect_o       = ctl_r[0];
    assign sleep_entry_o             = ctl_r[1];
    assign standby_entry_o           = ctl_r[2];
    assign neutral_sim_en_o          = ctl_r[3];
    assign undervoltage_lockout_en_o = ctl_r[4];
    assign ext_oc_detect_en_o        = ctl_r[5];
    assign ext_oc_thresh_o           = ctl_r[7:6];
    assign clref_uv_o                = uv_r;

    // ==========================================================
    // checks
    hdr_ack_code_a: assert property (@(posedge clk_i) disable iff (srst_i)
        req_take |=> (tx_byte_o[5:0] == $past(req_cmd_i[5:0])) && (tx_byte_o[6] == $past(req_ack)))
        else $error("header code or ack wrong");
    hdr_bit7_a: assert property (@(posedge clk_i) disable iff (srst_i)
        req_take |=> !tx_byte_o[7] && tx_valid_o)
        else $error("reply header bit 7 set");
    cfga_rsvd_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !drive_config_a_o[7])
        else $error("config bit 7 not zero");
    write_effect_a: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_cfga |=> drive_config_a_o == ($past(req_data_i) & 8'h7f))
        else $error("config write not applied");
    sleep_guard_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !in_standby_i |=> $stable(drive_config_a_o[5]))
        else $error("sleep select changed out of standby");
    unsol_hdr_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (unsol_go && pend0) |=> tx_byte_o == 8'h85)
        else $error("status 0 unsolicited header wrong");
    unsol1_hdr_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (unsol_go && !pend0) |=> tx_byte_o == 8'h86)
        else $error("status 1 unsolicited header wrong");
    nack_short_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_take && !req_ack) |=> tx_valid_o && tx_last_o)
        else $error("refused reply not single byte");
    sleep_pu_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (!drive_en_i && asleep) |=> pullup_disconnect_o && sleep_entry_o)
        else $error("sleep did not force pull-up disconnect");
    // header accepted on an acknowledged reply: the data byte follows
    wire data_go = (state_r == csre_pkg::CSRE_HDR) & ack_r & tx_fire;
    nack_end_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_r == csre_pkg::CSRE_HDR && !ack_r && tx_fire) |=> !tx_valid_o)
        else $error("refused reply went on past its header");
    byte_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_byte_o) && $stable(tx_last_o))
        else $error("reply byte changed while stalled");
    cfga_data_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (data_go && src_r == csre_pkg::CSRE_SRC_CFGA) |=> tx_last_o && !tx_byte_o[7]
            && (tx_byte_o == drive_config_a_o))
        else $error("config reply data byte wrong");
    clref_effect_a: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_clref |=> current_limit_reference_o == $past(req_data_i))
        else $error("reference write not applied");
    cfg_lost_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_cfga || wr_clref) |=> !cfg_lost_r)
        else $error("config lost flag not cleared by write");
    sts1_rsvd_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (data_go && src_r == csre_pkg::CSRE_SRC_STS1) |=> (tx_byte_o & 8'hc3) == 8'h00)
        else $error("status 1 reserved bit set");
    busy_ready_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !idle |=> !req_ready_o)
        else $error("request ready while busy");
    ctl_map_a: assert property (@(posedge clk_i) disable iff (srst_i)
        1'b1 |=> (neutral_sim_en_o == $past(drive_config_a_o[4]))
            && (undervoltage_lockout_en_o == !$past(drive_config_a_o[3]))
            && (ext_oc_detect_en_o == !$past(drive_config_a_o[2]))
            && (ext_oc_thresh_o == $past(drive_config_a_o[1:0])))
        else $error("config controls not decoded");
    standby_pu_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (!drive_en_i && !asleep) |=> standby_entry_o && !sleep_entry_o
            && (pullup_disconnect_o == !$past(drive_config_a_o[6])))
        else $error("standby pull-up control wrong");
    drive_on_a: assert property (@(posedge clk_i) disable iff (srst_i)
        drive_en_i |=> !pullup_disconnect_o && !sleep_entry_o && !standby_entry_o)
        else $error("low-power control active while driving");
    uv_map_a: assert property (@(posedge clk_i) disable iff (srst_i)
        1'b1 |=> clref_uv_o == 32'(`CSRE_CLREF_OFS_UV)
            + 32'($past(current_limit_reference_o)) * 32'(`CSRE_CLREF_STEP_UV))
        else $error("reference voltage mapping wrong");
endmodule : csre_encoder
`default_nettype wire

// ### csre_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host side: one request per reply, reply bytes taken with a stall pattern
module csre_host_model (
    input  wire logic       clk_i,
    input  wire logic       req_ready_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_byte_i,
    input  wire logic       tx_last_i,
    output logic            req_valid_o,
    output logic [7:0]      req_cmd_o,
    output logic [7:0]      req_data_o,
    output logic            tx_ready_o
);
    initial begin
        req_valid_o = 1'b0;
        req_cmd_o   = 8'h00;
        req_data_o  = 8'h00;
        tx_ready_o  = 1'b0;
    end
    // ready is high one cycle in st+1, so st=0 never stalls
    task automatic collect(input int st, output logic [7:0] h, output logic [7:0] v,
                           output int n);
        int i;
        bit done;
        n = 0;
        h = 8'h00;
        v = 8'h00;
        done = 1'b0;
        i = 0;
        while (!done && i < 200) begin
            @(negedge clk_i);
            tx_ready_o = (i % (st + 1)) == st;
            if (tx_ready_o && tx_valid_i) begin
                if (n == 0) h = tx_byte_i;
                else v = tx_byte_i;
                n++;
                done = tx_last_i;
            end
            i++;
        end
        @(negedge clk_i);
        tx_ready_o = 1'b0;
    endtask : collect
    task automatic transact(input logic [7:0] c, input logic [7:0] d, input int st,
                            output logic [7:0] h, output logic [7:0] v, output int n);
        int i;
        i = 0;
        @(negedge clk_i);
        while (req_ready_i !== 1'b1 && i < 200) begin
            @(negedge clk_i);
            i++;
        end
        req_valid_o = 1'b1;
        req_cmd_o   = c;
        req_data_o  = d;
        @(negedge clk_i);
        // released lines show the inverse so stale values cannot pass
        req_valid_o = 1'b0;
        req_cmd_o   = ~c;
        req_data_o  = ~d;
        collect(st, h, v, n);
    endtask : transact
endmodule : csre_host_model
`default_nettype wire

// ### csre_encoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "csre_defs.svh"
module csre_encoder_bench;
    logic        clk_i, srst_i, req_valid, req_ready, tx_valid, tx_ready, tx_last;
    logic [7:0]  req_cmd, req_data, sts0, sts1, tx_byte, cfg, clref;
    logic        in_standby, drive_en, pu_disc, sleep_ent, stby_ent, neusim, undervoltage_lockout_en, oc_en;
    logic [1:0]  oc_thr;
    logic [31:0] uv;
    int          fails, check_count;
    logic [7:0]  tbl [4] = '{8'h80, 8'hd5, 8'h2a, 8'h7f};
    csre_encoder csre_encoder_i (.clk_i(clk_i), .srst_i(srst_i), .req_valid_i(req_valid),
        .req_cmd_i(req_cmd), .req_data_i(req_data), .in_standby_i(in_standby),
        .drive_en_i(drive_en), .sts0_i(sts0), .sts1_i(sts1), .tx_ready_i(tx_ready),
        .req_ready_o(req_ready), .tx_valid_o(tx_valid), .tx_byte_o(tx_byte),
        .tx_last_o(tx_last), .drive_config_a_o(cfg), .current_limit_reference_o(clref),
        .pullup_disconnect_o(pu_disc), .sleep_entry_o(sleep_ent),
        .standby_entry_o(stby_ent), .neutral_sim_en_o(neusim),
        .undervoltage_lockout_en_o(undervoltage_lockout_en), .ext_oc_detect_en_o(oc_en),
        .ext_oc_thresh_o(oc_thr), .clref_uv_o(uv));
    csre_host_model csre_host_model_i (.clk_i(clk_i), .req_ready_i(req_ready),
        .tx_valid_i(tx_valid), .tx_byte_i(tx_byte), .tx_last_i(tx_last),
        .req_valid_o(req_valid), .req_cmd_o(req_cmd), .req_data_o(req_data),
        .tx_ready_o(tx_ready));
    // ==========================================================
    // checking helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // command 00h means no request: wait for an unsolicited frame
    task automatic xact(input logic [7:0] c, input logic [7:0] d, input logic [7:0] eh,
                        input logic [7:0] ed, input int en, input int st);
        logic [7:0] h, v;
        int n;
        if (c == 8'h00) csre_host_model_i.collect(st, h, v, n);
        else csre_host_model_i.transact(c, d, st, h, v, n);
        chk({24'h0, h}, {24'h0, eh});
        chk(n, en);
        if (en == 2) chk({24'h0, v}, {24'h0, ed});
    endtask : xact
    task automatic end_of_test;
        if (fails == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // ==========================================================
    // scenarios
    task automatic t_defaults;
        xact(8'h82, 8'h00, 8'h42, 8'h00, 2, 0);
        xact(8'h84, 8'h00, 8'h44, 8'h40, 2, 1);
        xact(8'h85, 8'h00, 8'h45, 8'h01, 2, 0);
        xact(8'h86, 8'h00, 8'h46, 8'h10, 2, 2);
        chk(uv, `CSRE_CLREF_OFS_UV + 8'h40 * `CSRE_CLREF_STEP_UV);
        chk({24'h0, pu_disc, sleep_ent, stby_ent, neusim, undervoltage_lockout_en, oc_en, oc_thr},
            {24'h0, 8'b10101100});
    endtask : t_defaults
    task automatic t_cfg_write;
        logic [7:0] e;
        for (int i = 0; i < 4; i++) begin
            e = tbl[i] & `CSRE_CFGA_MASK;
            xact(8'h81, tbl[i], 8'h41, e, 2, i);
            xact(8'h82, 8'h00, 8'h42, e, 2, 0);
            chk({24'h0, pu_disc, sleep_ent, stby_ent, neusim, undervoltage_lockout_en, oc_en, oc_thr},
                {24'h0, e[5] | ~e[6], e[5], ~e[5], e[4], ~e[3], ~e[2], e[1:0]});
            drive_en = 1'b1;
            repeat (2) @(negedge clk_i);
            chk({29'h0, pu_disc, sleep_ent, stby_ent}, 32'h0);
            drive_en = 1'b0;
        end
    endtask : t_cfg_write
    task automatic t_refuse;
        in_standby = 1'b0;
        xact(8'h81, 8'h5f, 8'h01, 8'h00, 1, 0);
        chk({24'h0, cfg}, {24'h0, 8'h7f});
        xact(8'h81, 8'h7e, 8'h41, 8'h7e, 2, 1);
        xact(8'h87, 8'h00, 8'h07, 8'h00, 1, 0);
        xact(8'h02, 8'h00, 8'h02, 8'h00, 1, 2);
        in_standby = 1'b1;
    endtask : t_refuse
    task automatic t_clref;
        logic [7:0] v;
        for (int i = 0; i < 2; i++) begin
            v = (i == 0) ? 8'hff : 8'h00;
            xact(8'h83, v, 8'h43, v, 2, 1);
            chk(uv, `CSRE_CLREF_OFS_UV + v * `CSRE_CLREF_STEP_UV);
            chk({24'h0, clref}, {24'h0, v});
            xact(8'h84, 8'h00, 8'h44, v, 2, 3);
        end
    endtask : t_clref
    task automatic t_status;
        sts1 = 8'h08;
        xact(8'h00, 8'h00, 8'h86, 8'h08, 2, 1);
        sts1 = 8'hec;
        xact(8'h00, 8'h00, 8'h86, 8'h2c, 2, 0);
        sts0 = 8'h80;
        xact(8'h00, 8'h00, 8'h85, 8'h80, 2, 2);
        sts0 = 8'hff;
        xact(8'h00, 8'h00, 8'h85, 8'hff, 2, 0);
        xact(8'h85, 8'h00, 8'h45, 8'hff, 2, 1);
        xact(8'h86, 8'h00, 8'h46, 8'h2c, 2, 0);
    endtask : t_status
    // mid-run reset with live faults up: no unsolicited frame may follow release
    task automatic t_reset;
        srst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        srst_i = 1'b0;
        xact(8'h86, 8'h00, 8'h46, 8'h3c, 2, 0);
        xact(8'h82, 8'h00, 8'h42, `CSRE_CFGA_RST, 2, 1);
        xact(8'h84, 8'h00, 8'h44, `CSRE_CLREF_RST, 2, 0);
        xact(8'h85, 8'h00, 8'h45, 8'hff, 2, 2);
        chk(uv, `CSRE_CLREF_OFS_UV + `CSRE_CLREF_RST * `CSRE_CLREF_STEP_UV);
    endtask : t_reset
    // ==========================================================
    // clock, reset, sequence and watchdog
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        fails = 0;
        check_count = 0;
        srst_i = 1'b1;
        in_standby = 1'b1;
        drive_en = 1'b0;
        sts0 = `CSRE_STS0_RST;
        sts1 = 8'h00;
        repeat (16) @(negedge clk_i);
        srst_i = 1'b0;
        t_defaults();
        t_cfg_write();
        t_refuse();
        t_clref();
        t_status();
        t_reset();
        end_of_test();
    end
    // the whole run needs a few hundred cycles
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule : csre_encoder_bench
`default_nettype wire
